// ==== rtl/pdt_pkg.sv ====
// Constants, register map and field layout of the two-channel down timer.
// Assumes a 20 MHz MCLK and an APB master with 32-bit data.
package pdt_pkg;
    localparam int CNT_W = 8;
    localparam int NIB_W = 4;
    localparam int CH_N  = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] RELOAD0_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] RELOAD1_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] CH0_LO_OFS  = 8'h0C;
    localparam logic [ADDR_W-1:0] CH0_HI_OFS  = 8'h10;
    localparam logic [ADDR_W-1:0] CH1_LO_OFS  = 8'h14;
    localparam logic [ADDR_W-1:0] CH1_HI_OFS  = 8'h18;
    localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h1C;
    localparam logic [ADDR_W-1:0] PORT_OFS    = 8'h20;

    // Control register fields
    localparam int CTRL_RUN0     = 0;
    localparam int CTRL_OUT_EN   = 2;
    localparam int CTRL_EVT_MODE = 3;
    localparam int CTRL_HS_ON    = 4;
    localparam int CTRL_HS_SRC   = 5;
    localparam int CTRL_W        = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

    // Port register fields
    localparam int PORT_A_DATA  = 0;
    localparam int PORT_B_DATA  = 1;
    localparam int PORT_A_FLOAT = 2;
    localparam int PORT_B_FLOAT = 3;
    localparam int PORT_A_SPEC  = 4;
    localparam int PORT_B_SPEC  = 5;
    localparam int PORT_W       = 6;
    localparam logic [PORT_W-1:0] PORT_RST = 6'h03;

    localparam logic [CNT_W-1:0] CNT_RST    = 8'hFF;
    localparam logic [CNT_W-1:0] RELOAD_RST = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

    // Clock rates turned into half-period counts of MCLK
    localparam int MCLK_HZ    = 20_000_000;
    localparam int LS_HZ      = 32_768;
    localparam int HS_HZ      = 4_000_000;
    localparam int LS_HALF    = MCLK_HZ / (2 * LS_HZ);
    localparam int HS_HALF    = MCLK_HZ / (2 * HS_HZ);
    localparam int DIV_W      = 9;
    localparam logic [DIV_W-1:0] LS_HALF_CNT = DIV_W'(LS_HALF - 1);
    localparam logic [DIV_W-1:0] HS_HALF_CNT = DIV_W'(HS_HALF - 1);
endpackage

// ==== rtl/pdt_top.sv ====
// Two-channel 8-bit programmable down timer with APB register access.
// Assumes an APB master on MCLK; the event pin is asynchronous to MCLK.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module pdt_top
(
    input  wire logic                          MCLK,
    input  wire logic                          RST,
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [pdt_pkg::ADDR_W-1:0]    PADDR,
    input  wire logic [pdt_pkg::DATA_W-1:0]    PWDATA,
    output logic      [pdt_pkg::DATA_W-1:0]    PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    input  wire logic                          EVENT_CLOCK_INPUT_PIN,
    output logic                               EVENT_PORT_LEVEL,
    output logic                               HIGH_SPEED_OSCILLATOR_EN,
    output logic                               TIMER_SQUARE_OUTPUT,
    output logic                               SPECIAL_OUTPUT_PIN_A_O,
    output logic                               SPECIAL_OUTPUT_PIN_A_OE,
    output logic                               SPECIAL_OUTPUT_PIN_B_O,
    output logic                               SPECIAL_OUTPUT_PIN_B_OE
);
    import pdt_pkg::*;

    logic [CTRL_W-1:0]  ctrl_reg;
    logic [PORT_W-1:0]  port_reg;
    logic [CNT_W-1:0]   reload_reg [CH_N];
    logic [CNT_W-1:0]   count_reg  [CH_N];
    logic [NIB_W-1:0]   hi_buf_reg [CH_N];
    logic [CH_N-1:0]    run_reg;
    logic [CH_N-1:0]    active_reg;
    logic [CH_N-1:0]    prev_lvl_reg;
    logic [CH_N-1:0]    lvl;
    logic [CH_N-1:0]    fall;
    logic [CH_N-1:0]    under;
    logic [CH_N-1:0]    flag_reg;
    logic [CH_N-1:0]    flag_next;
    logic [CH_N-1:0]    flag_clr;
    logic [CH_N-1:0]    reload_wr;
    logic               timer_square_output_reg;
    logic               evt_s1_reg;
    logic               evt_s2_reg;
    logic [DIV_W-1:0]   ls_div_reg;
    logic [DIV_W-1:0]   hs_div_reg;
    logic               ls_lvl_reg;
    logic               hs_lvl_reg;
    logic               wr_en;
    logic               rd_setup;
    logic [DATA_W-1:0]  rd_mux;
    logic               addr_ok;

    assign wr_en    = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    // Zero wait states: read data is captured in the setup cycle
    assign PREADY   = 1'b1;

    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux  = '0;
        unique case (PADDR)
            CTRL_OFS:    rd_mux = DATA_W'({ctrl_reg[CTRL_W-1:CH_N], run_reg | active_reg});
            RELOAD0_OFS: rd_mux = DATA_W'(reload_reg[0]);
            RELOAD1_OFS: rd_mux = DATA_W'(reload_reg[1]);
            CH0_LO_OFS:  rd_mux = DATA_W'(count_reg[0][NIB_W-1:0]);
            CH0_HI_OFS:  rd_mux = DATA_W'(hi_buf_reg[0]);
            CH1_LO_OFS:  rd_mux = DATA_W'(count_reg[1][NIB_W-1:0]);
            CH1_HI_OFS:  rd_mux = DATA_W'(hi_buf_reg[1]);
            STATUS_OFS:  rd_mux = DATA_W'(flag_reg);
            PORT_OFS:    rd_mux = DATA_W'(port_reg);
            default:     addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end
        else if (PSEL && !PENABLE)
        begin
            PRDATA  <= PWRITE ? '0 : rd_mux;
            PSLVERR <= !addr_ok;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_reg <= CTRL_RST;
            port_reg <= PORT_RST;
            run_reg  <= '0;
        end
        else if (wr_en && PADDR == CTRL_OFS)
        begin
            ctrl_reg <= PWDATA[CTRL_W-1:0];
            run_reg  <= PWDATA[CH_N-1:0];
        end
        else if (wr_en && PADDR == PORT_OFS)
        begin
            port_reg <= PWDATA[PORT_W-1:0];
        end
    end

    assign HIGH_SPEED_OSCILLATOR_EN = ctrl_reg[CTRL_HS_ON];

    assign flag_clr  = (wr_en && PADDR == STATUS_OFS) ? PWDATA[CH_N-1:0] : '0;
    assign flag_next = (flag_reg & ~flag_clr) | under;
    assign reload_wr = {wr_en && PADDR == RELOAD1_OFS, wr_en && PADDR == RELOAD0_OFS};

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            flag_reg <= '0;
        else
            flag_reg <= flag_next;
    end

    // Event pin synchroniser; the port sees the same level as the timer
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            evt_s1_reg <= 1'b0;
            evt_s2_reg <= 1'b0;
        end
        else
        begin
            evt_s1_reg <= EVENT_CLOCK_INPUT_PIN;
            evt_s2_reg <= evt_s1_reg;
        end
    end

    assign EVENT_PORT_LEVEL = evt_s2_reg;

    // Source clocks; the fast one runs only while its oscillator is on
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ls_div_reg <= '0;
            ls_lvl_reg <= 1'b0;
        end
        else if (ls_div_reg == LS_HALF_CNT)
        begin
            ls_div_reg <= '0;
            ls_lvl_reg <= !ls_lvl_reg;
        end
        else
            ls_div_reg <= ls_div_reg + 1'b1;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            hs_div_reg <= '0;
            hs_lvl_reg <= 1'b0;
        end
        else if (!ctrl_reg[CTRL_HS_ON])
            hs_div_reg <= '0;
        else if (hs_div_reg == HS_HALF_CNT)
        begin
            hs_div_reg <= '0;
            hs_lvl_reg <= !hs_lvl_reg;
        end
        else
            hs_div_reg <= hs_div_reg + 1'b1;
    end

    genvar ch;
    generate
        for (ch = 0; ch < CH_N; ch++)
        begin : g_ch
            logic int_lvl;
            assign int_lvl = ctrl_reg[CTRL_HS_SRC] ? hs_lvl_reg : ls_lvl_reg;
            // Only channel 0 may count pulses from the event pin
            assign lvl[ch] = (ch == 0 && ctrl_reg[CTRL_EVT_MODE]) ? evt_s2_reg : int_lvl;
            assign fall[ch] = prev_lvl_reg[ch] && !lvl[ch];
            assign under[ch] = fall[ch] && active_reg[ch] && count_reg[ch] == CNT_ZERO;

            always_ff @(posedge MCLK or posedge RST)
            begin
                if (RST)
                begin
                    prev_lvl_reg[ch] <= 1'b0;
                    active_reg[ch]   <= 1'b0;
                end
                else
                begin
                    prev_lvl_reg[ch] <= lvl[ch];
                    if (fall[ch])
                        active_reg[ch] <= run_reg[ch];
                end
            end

            always_ff @(posedge MCLK or posedge RST)
            begin
                if (RST)
                    reload_reg[ch] <= RELOAD_RST;
                else if (reload_wr[ch])
                    reload_reg[ch] <= PWDATA[CNT_W-1:0];
            end

            always_ff @(posedge MCLK or posedge RST)
            begin
                if (RST)
                    count_reg[ch] <= CNT_RST;
                else if (fall[ch] && active_reg[ch])
                    count_reg[ch] <= under[ch] ? reload_reg[ch] : count_reg[ch] - 1'b1;
                else if (reload_wr[ch] && !active_reg[ch])
                    count_reg[ch] <= PWDATA[CNT_W-1:0];
            end

            // Low-nibble read freezes the high nibble for the paired read
            always_ff @(posedge MCLK or posedge RST)
            begin
                if (RST)
                    hi_buf_reg[ch] <= '0;
                else if (rd_setup && PADDR == (ch == 0 ? CH0_LO_OFS : CH1_LO_OFS))
                    hi_buf_reg[ch] <= count_reg[ch][CNT_W-1:NIB_W];
            end

            AST_RUN_AT_FALL: assert property (@(posedge MCLK) disable iff (RST)
                (active_reg[ch] != $past(active_reg[ch])) |-> $past(fall[ch]))
                else $error("Run state changed without a falling input edge");
            AST_STOP_ON_DECREMENT: assert property (@(posedge MCLK) disable iff (RST)
                ($fell(active_reg[ch]) && $past(count_reg[ch]) != CNT_ZERO)
                |-> count_reg[ch] == $past(count_reg[ch]) - 1'b1)
                else $error("Counter did not decrement on the stopping edge");
            AST_RUN_READBACK: assert property (@(posedge MCLK) disable iff (RST)
                (active_reg[ch] && PADDR == CTRL_OFS) |-> rd_mux[ch])
                else $error("Run bit read zero before counter stopped");
            AST_HOLD_NO_PULSE: assert property (@(posedge MCLK) disable iff (RST)
                (!fall[ch] && !reload_wr[ch]) |=> count_reg[ch] == $past(count_reg[ch]))
                else $error("Counter moved without an input clock edge");
            AST_UNDERFLOW_FLAG: assert property (@(posedge MCLK) disable iff (RST)
                under[ch] |=> flag_reg[ch] && count_reg[ch] == $past(reload_reg[ch]))
                else $error("Underflow did not reload and flag");
        end
    endgenerate

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            timer_square_output_reg <= 1'b0;
        else if (under[1])
            timer_square_output_reg <= !timer_square_output_reg;
    end

    // Plain AND gate: switching the enable may clip up to half a cycle
    assign TIMER_SQUARE_OUTPUT = timer_square_output_reg && ctrl_reg[CTRL_OUT_EN];

    assign SPECIAL_OUTPUT_PIN_A_O  = port_reg[PORT_A_DATA] &&
                                     (!port_reg[PORT_A_SPEC] || TIMER_SQUARE_OUTPUT);
    assign SPECIAL_OUTPUT_PIN_A_OE = !port_reg[PORT_A_FLOAT];
    assign SPECIAL_OUTPUT_PIN_B_O  = port_reg[PORT_B_DATA] &&
                                     (!port_reg[PORT_B_SPEC] || TIMER_SQUARE_OUTPUT);
    assign SPECIAL_OUTPUT_PIN_B_OE = !port_reg[PORT_B_FLOAT];

    AST_OSC_OFF_RESET: assert property (@(posedge MCLK)
        $fell(RST) |-> !HIGH_SPEED_OSCILLATOR_EN)
        else $error("Fast oscillator on after reset");
    AST_SQUARE_GATE: assert property (@(posedge MCLK) disable iff (RST)
        !ctrl_reg[CTRL_OUT_EN] |-> !TIMER_SQUARE_OUTPUT)
        else $error("Square output active while disabled");
    AST_PORT_SEES_PIN: assert property (@(posedge MCLK) disable iff (RST)
        ##2 EVENT_PORT_LEVEL == $past(EVENT_CLOCK_INPUT_PIN, 2))
        else $error("Port level lost an event pin edge");
    AST_PIN_LOW_ON_ZERO: assert property (@(posedge MCLK) disable iff (RST)
        (!port_reg[PORT_A_DATA] && !port_reg[PORT_A_FLOAT]) |->
        (SPECIAL_OUTPUT_PIN_A_OE && !SPECIAL_OUTPUT_PIN_A_O))
        else $error("Pin A not driven low with zero data");
    AST_PIN_FLOATS: assert property (@(posedge MCLK) disable iff (RST)
        port_reg[PORT_B_FLOAT] |-> !SPECIAL_OUTPUT_PIN_B_OE)
        else $error("Pin B driven while float control set");
endmodule
`default_nettype wire

// ==== verification/pdt_evt_src.sv ====
// Partner model: external event clock source on the shared input pin.
// Assumes the bench raises go for one clock while busy is low.
`timescale 1ns/1ns
`default_nettype none
module pdt_evt_src
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [3:0] pulses,
    input  wire logic [7:0] half,
    output logic            pin,
    output logic            busy
);
    logic [3:0] left_reg;
    logic [7:0] cnt_reg;
    // Pin rests low between bursts, so no edge reaches the timer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin <= 1'b0;
            busy <= 1'b0;
            left_reg <= 4'h0;
            cnt_reg <= 8'h00;
        end
        else if (go && !busy)
        begin
            busy <= 1'b1;
            pin <= 1'b1;
            left_reg <= pulses;
            cnt_reg <= half;
        end
        else if (busy && cnt_reg > 8'h01)
            cnt_reg <= cnt_reg - 8'h01;
        else if (busy)
        begin
            cnt_reg <= half;
            pin <= !pin && left_reg != 4'h0;
            busy <= pin || left_reg != 4'h0;
            left_reg <= pin ? left_reg - 4'h1 : left_reg;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the two-channel down timer.
// Assumes APB with no wait states expected but waits for PREADY anyway.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pdt_pkg::*;
    // Settling is not modelled by the design, so a short wait stands in
    localparam int OSC_SETTLE = 2000;
    logic        mclk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, err, sq_q;
    logic [7:0]  paddr = 8'h00;
    logic [3:0]  npl = 4'h0;
    logic [31:0] pwdata = 32'h0, rd, prdata, lfsr = 32'hC425EECE;
    logic        pready, pslverr, pin, busy, plev, hsen, sq, ao, aoe, bo, boe;
    integer      fails = 0, check_count = 0, cyc = 0, i, tg, bad;
    integer      m_cnt, m_rl, m_act = 0, m_run = 0, m_flag = 0;
    logic [7:0]  adr [6] = '{CTRL_OFS, RELOAD0_OFS, RELOAD1_OFS, STATUS_OFS, PORT_OFS, CH0_LO_OFS};
    logic [31:0] rsv [6] = '{32'h0, 32'hFF, 32'hFF, 32'h0, 32'h3, 32'hF};
    initial forever #25 mclk = ~mclk;
    pdt_top pdt_top_inst (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EVENT_CLOCK_INPUT_PIN(pin), .EVENT_PORT_LEVEL(plev), .HIGH_SPEED_OSCILLATOR_EN(hsen),
        .TIMER_SQUARE_OUTPUT(sq), .SPECIAL_OUTPUT_PIN_A_O(ao), .SPECIAL_OUTPUT_PIN_A_OE(aoe),
        .SPECIAL_OUTPUT_PIN_B_O(bo), .SPECIAL_OUTPUT_PIN_B_OE(boe));
    pdt_evt_src pdt_evt_src_inst (.clk(mclk), .rst(rst), .go(go), .pulses(npl), .half(8'h08),
        .pin(pin), .busy(busy));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        // The wait ends when PREADY is high; nothing but the bench timeout limits it
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Reference: activity takes the run bit at each falling edge, after counting
    task automatic m_edge();
        if (m_act != 0)
        begin
            if (m_cnt == 0)
            begin
                m_cnt = m_rl;
                m_flag = 1;
            end
            else
                m_cnt--;
        end
        m_act = m_run;
    endtask
    task automatic burst(input int n);
        int k;
        npl <= 4'(n);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (5) @(posedge mclk);
        chk("port_level_high", 1, plev);
        while (busy !== 1'b0)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
        chk("port_level_low", 0, plev);
        for (k = 0; k < n; k++)
            m_edge();
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            finish_test();
        end
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("osc_en_reset", 0, hsen);
        chk("pin_a_reset", 32'h3, {ao, aoe});
        for (i = 0; i < 6; i++)
            rdchk("reset_value", adr[i], rsv[i]);
        apb(1'b1, 8'h24, 32'h5);
        chk("unmapped_err", 1, err);
        lfsr = lfsr_next(lfsr);
        m_rl = lfsr[7:0];
        apb(1'b1, RELOAD0_OFS, 32'(m_rl));
        rdchk("ch0_low", CH0_LO_OFS, m_rl & 15);
        apb(1'b1, RELOAD0_OFS, 32'h3);
        rdchk("ch0_high_latched", CH0_HI_OFS, m_rl >> 4);
        m_rl = 3;
        m_cnt = 3;
        rdchk("ch0_low_new", CH0_LO_OFS, m_cnt & 15);
        rdchk("ch0_high", CH0_HI_OFS, m_cnt >> 4);
        m_run = 1;
        apb(1'b1, CTRL_OFS, 32'h09);
        repeat (20) @(posedge mclk);
        rdchk("ch0_idle", CH0_LO_OFS, m_cnt & 15);
        burst(4);
        rdchk("ch0_run", CH0_LO_OFS, m_cnt & 15);
        rdchk("status_run", STATUS_OFS, m_flag);
        burst(1);
        rdchk("ch0_reload", CH0_LO_OFS, m_cnt & 15);
        rdchk("status_flag", STATUS_OFS, m_flag);
        apb(1'b1, STATUS_OFS, 32'h1);
        m_flag = 0;
        rdchk("status_clear", STATUS_OFS, m_flag);
        m_run = 0;
        apb(1'b1, CTRL_OFS, 32'h08);
        rdchk("run_held", CTRL_OFS, 32'h09);
        burst(1);
        rdchk("run_stopped", CTRL_OFS, 32'h08);
        rdchk("ch0_stop_dec", CH0_LO_OFS, m_cnt & 15);
        burst(2);
        rdchk("ch0_halted", CH0_LO_OFS, m_cnt & 15);
        apb(1'b1, RELOAD1_OFS, 32'h1);
        rdchk("ch1_low", CH1_LO_OFS, 32'h1);
        rdchk("ch1_high", CH1_HI_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h30);
        chk("osc_en_on", 1, hsen);
        repeat (OSC_SETTLE) @(posedge mclk);
        apb(1'b1, PORT_OFS, 32'h31);
        apb(1'b1, CTRL_OFS, 32'h36);
        tg = 0;
        bad = 0;
        sq_q = sq;
        for (i = 0; i < 96; i++)
        begin
            @(negedge mclk);
            tg = tg + (sq !== sq_q);
            sq_q = sq;
            bad = bad + (ao !== sq || bo !== 1'b0);
        end
        chk("square_toggles", 1, 32'(tg >= 8 && tg <= 14));
        chk("special_pins", 0, bad);
        @(posedge mclk);
        apb(1'b1, CTRL_OFS, 32'h32);
        for (i = 0; i < 40; i++)
        begin
            @(negedge mclk);
            bad = bad + (sq !== 1'b0);
        end
        chk("square_gated", 0, bad);
        @(posedge mclk);
        apb(1'b1, PORT_OFS, 32'h3D);
        chk("pins_float", 0, {aoe, boe});
        finish_test();
    end
endmodule
`default_nettype wire
